// File: tsc_regs.sv
// Behaviour
// - standby touch when delta above 7-bit threshold
// - accumulate samples, keep upper 16, clear
// - three read-only base counts, reset c8
// - base shift picks shown base bits
// - select code 0/1/2 picks input 1/2/3
// - active hold detection needs active enable
// - standby hold detection needs standby enable
// - active hold time from 2-bit code
// - standby hold time, same encoding
// - flag and event after full hold
// - 10-bit calibration, high and packed low
// - calibration at min or max fails
// - per-input calibration gain 1, 2, 4
// - read-only identity registers at top
// - standby inputs compared against standby threshold
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defs.svh"

module tsc_regs import tsc_pkg::*; #(
  parameter int HOLD_BASE_CYCLES = `TSC_HOLD_BASE_CYCLES,
  parameter int SAMPLES_LOG2 = `TSC_BASE_SAMPLES_LOG2,
  // identity values are arbitrary
  parameter logic [7:0] PRODUCT_CODE = 8'ha5,
  parameter logic [7:0] VENDOR_CODE = 8'h3c,
  parameter logic [7:0] REVISION_CODE = 8'h01
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register port from the serial front end
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rdata,
  // sensing state
  input wire logic device_standby,
  input wire logic [2:0] standby_channel_enable,
  input wire logic [7:0] touch_input_1_delta,
  input wire logic [7:0] touch_input_2_delta,
  input wire logic [7:0] touch_input_3_delta,
  input wire logic [2:0] active_touch,
  output logic [2:0] standby_touch,
  // base count calibration
  input wire logic [3:0] base_shift,
  input wire logic cal_sample_valid,
  input wire logic [1:0] cal_sample_channel,
  input wire logic [15:0] cal_sample_count,
  // analog calibration
  input wire logic analog_cal_done,
  input wire logic [1:0] analog_cal_channel,
  input wire logic [9:0] analog_cal_value,
  output logic [2:0] analog_cal_fail,
  output logic [1:0] calib_gain_shift_1,
  output logic [1:0] calib_gain_shift_2,
  output logic [1:0] calib_gain_shift_3,
  // hold key
  input wire logic hold_key_status_clear,
  output logic hold_key_event,
  output logic hold_key_status_flag
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic tsc_byte_t shift_base(input logic [15:0] word, input logic [3:0] sh);
    logic [15:0] t;
    t = word >> sh;
    return t[7:0];
  endfunction : shift_base

  // reserved code 11 falls back to unity gain
  function automatic logic [1:0] gain_shift(input logic [1:0] code);
    case (code)
      2'b01: return 2'h1;
      2'b10: return 2'h2;
      default: return 2'h0;
    endcase
  endfunction : gain_shift

  // ****************************************************************
  // writable registers
  // ****************************************************************
  logic [6:0] thresh_q;
  logic [2:0] hold_sel_q;
  logic [7:0] hold_cfg_q;
  logic [5:0] gain_q;
  logic wr_thresh, wr_sel, wr_cfg, wr_gain;

  assign wr_thresh = reg_wr_en && (reg_addr == `TSC_ADDR_STBY_THRESH);
  assign wr_sel = reg_wr_en && (reg_addr == `TSC_ADDR_HOLD_SEL);
  assign wr_cfg = reg_wr_en && (reg_addr == `TSC_ADDR_HOLD_CFG);
  assign wr_gain = reg_wr_en && (reg_addr == `TSC_ADDR_CAL_GAIN);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      thresh_q <= `TSC_RST_STBY_THRESH;
    end else if (wr_thresh) begin
      thresh_q <= reg_wdata[6:0];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_sel_q <= `TSC_RST_HOLD_SEL;
    end else if (wr_sel) begin
      hold_sel_q <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_cfg_q <= `TSC_RST_HOLD_CFG;
    end else if (wr_cfg) begin
      hold_cfg_q <= reg_wdata & `TSC_MASK_HOLD_CFG;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gain_q <= `TSC_RST_CAL_GAIN;
    end else if (wr_gain) begin
      gain_q <= reg_wdata[5:0];
    end
  end

  assign calib_gain_shift_1 = gain_shift(gain_q[1:0]);
  assign calib_gain_shift_2 = gain_shift(gain_q[3:2]);
  assign calib_gain_shift_3 = gain_shift(gain_q[5:4]);

  // ****************************************************************
  // standby touch compare
  // ****************************************************************
  // delta is taken as an unsigned magnitude; negative swings are the engine's concern
  logic [7:0] delta [3];
  assign delta[0] = touch_input_1_delta;
  assign delta[1] = touch_input_2_delta;
  assign delta[2] = touch_input_3_delta;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      standby_touch <= 3'b000;
    end else begin
      for (int i = 0; i < 3; i++) begin
        standby_touch[i] <= device_standby && standby_channel_enable[i] &&
                            (delta[i] > {1'b0, thresh_q});
      end
    end
  end

  // ****************************************************************
  // base counts
  // ****************************************************************
  logic [2:0] base_valid;
  logic [15:0] base_word [3];
  tsc_byte_t base_q [3];

  for (genvar g = 0; g < 3; g++) begin : g_base
    tsc_base_acc #(
      .SAMPLES_LOG2(SAMPLES_LOG2),
      .CHANNEL(2'(g))
    ) u_acc (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .sample_valid(cal_sample_valid),
      .sample_channel(cal_sample_channel),
      .sample_count(cal_sample_count),
      .base_valid(base_valid[g]),
      .base_word(base_word[g])
    );
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 3; i++) begin
        base_q[i] <= `TSC_RST_BASE;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (base_valid[i]) begin
          base_q[i] <= shift_base(base_word[i], base_shift);
        end
      end
    end
  end

  // ****************************************************************
  // analog calibration readback
  // ****************************************************************
  logic [9:0] cal_q [3];

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 3; i++) begin
        cal_q[i] <= `TSC_RST_CAL;
      end
      analog_cal_fail <= 3'b000;
    end else if (analog_cal_done && (analog_cal_channel != 2'h3)) begin
      cal_q[analog_cal_channel] <= analog_cal_value;
      analog_cal_fail[analog_cal_channel] <= (analog_cal_value == `TSC_CAL_MIN) ||
                                             (analog_cal_value == `TSC_CAL_MAX);
    end
  end

  // ****************************************************************
  // hold key detection
  // ****************************************************************
  logic [2:0] touch_vec;
  logic hold_touch, hold_enable, hold_fire;
  logic [1:0] hold_code;

  assign touch_vec = device_standby ? standby_touch : active_touch;

  always_comb begin
    case (hold_sel_q)
      3'h0: hold_touch = touch_vec[0];
      3'h1: hold_touch = touch_vec[1];
      3'h2: hold_touch = touch_vec[2];
      default: hold_touch = 1'b0;
    endcase
  end

  assign hold_enable = device_standby ? hold_cfg_q[`TSC_CFG_STBY_EN] :
                                        hold_cfg_q[`TSC_CFG_ACT_EN];
  assign hold_code = device_standby ?
                     hold_cfg_q[`TSC_CFG_STBY_TIME_HI:`TSC_CFG_STBY_TIME_LO] :
                     hold_cfg_q[`TSC_CFG_ACT_TIME_HI:`TSC_CFG_ACT_TIME_LO];

  tsc_hold_timer #(
    .HOLD_BASE_CYCLES(HOLD_BASE_CYCLES)
  ) u_hold (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .touch(hold_touch),
    .enable(hold_enable),
    .time_code(hold_code),
    .fire(hold_fire)
  );

  // a clear arriving with a new hold loses, so no press is dropped
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_key_event <= 1'b0;
      hold_key_status_flag <= 1'b0;
    end else begin
      hold_key_event <= hold_fire;
      hold_key_status_flag <= hold_fire || (hold_key_status_flag && !hold_key_status_clear);
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  tsc_byte_t rd_mux;

  always_comb begin
    case (reg_addr)
      `TSC_ADDR_STBY_THRESH: rd_mux = {1'b0, thresh_q};
      `TSC_ADDR_BASE1: rd_mux = base_q[0];
      `TSC_ADDR_BASE2: rd_mux = base_q[1];
      `TSC_ADDR_BASE3: rd_mux = base_q[2];
      `TSC_ADDR_HOLD_SEL: rd_mux = {5'h00, hold_sel_q};
      `TSC_ADDR_HOLD_CFG: rd_mux = hold_cfg_q;
      `TSC_ADDR_CAL_GAIN: rd_mux = {2'h0, gain_q};
      `TSC_ADDR_CAL1: rd_mux = cal_q[0][9:2];
      `TSC_ADDR_CAL2: rd_mux = cal_q[1][9:2];
      `TSC_ADDR_CAL3: rd_mux = cal_q[2][9:2];
      `TSC_ADDR_CAL_LSB: rd_mux = {2'h0, cal_q[2][1:0], cal_q[1][1:0], cal_q[0][1:0]};
      `TSC_ADDR_PRODUCT: rd_mux = PRODUCT_CODE;
      `TSC_ADDR_VENDOR: rd_mux = VENDOR_CODE;
      `TSC_ADDR_REVISION: rd_mux = REVISION_CODE;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rdata <= rd_mux;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence fire_seq;
    hold_fire;
  endsequence

  sequence clear_only_seq;
    hold_key_status_flag && hold_key_status_clear && !hold_fire;
  endsequence

  thresh_touch_a: assert property (
    (device_standby && standby_channel_enable[0] && (touch_input_1_delta > {1'b0, thresh_q}))
      |=> standby_touch[0])
    else $error("standby touch missed above threshold");

  thresh_quiet_a: assert property (
    (!standby_channel_enable[0] || (touch_input_1_delta <= {1'b0, thresh_q})) |=> !standby_touch[0])
    else $error("standby touch without enable or above-threshold delta");

  base_shift_a: assert property (
    base_valid[1] |=> base_q[1] == shift_base($past(base_word[1]), $past(base_shift)))
    else $error("base count not the shifted base word");

  sel_decode_a: assert property (
    (hold_sel_q == 3'h2) |-> (hold_touch == touch_vec[2]))
    else $error("select code 2 does not pick input 3");

  active_gate_a: assert property (
    (!device_standby && !hold_cfg_q[`TSC_CFG_ACT_EN])[*3] |-> !hold_key_event)
    else $error("active hold event while active detection disabled");

  standby_gate_a: assert property (
    (device_standby && !hold_cfg_q[`TSC_CFG_STBY_EN])[*3] |-> !hold_key_event)
    else $error("standby hold event while standby detection disabled");

  hold_time_a: assert property (
    u_hold.target == (32'(HOLD_BASE_CYCLES) << (device_standby ?
                      hold_cfg_q[5:4] : hold_cfg_q[1:0])))
    else $error("hold time not taken from the state's time field");

  flag_set_a: assert property (
    fire_seq |=> hold_key_status_flag && hold_key_event)
    else $error("hold completion did not set flag and event");

  flag_clear_a: assert property (
    clear_only_seq |=> !hold_key_status_flag ##1 (hold_key_status_flag == $past(hold_fire)))
    else $error("status flag clear misbehaved");

  calib_store_a: assert property (
    (analog_cal_done && analog_cal_channel == 2'h1)
      |=> cal_q[1] == $past(analog_cal_value))
    else $error("calibration value not stored");

  calib_fail_a: assert property (
    (analog_cal_done && analog_cal_channel == 2'h2 && analog_cal_value == `TSC_CAL_MAX)
      |=> analog_cal_fail[2])
    else $error("full-scale calibration not flagged");

  id_read_a: assert property (
    (reg_rd_en && reg_addr == `TSC_ADDR_VENDOR) |=> reg_rdata == VENDOR_CODE)
    else $error("identity register read wrong");

  ro_write_a: assert property (
    (reg_wr_en && reg_addr == `TSC_ADDR_BASE1 && !base_valid[0]) |=> $stable(base_q[0]))
    else $error("write changed a read-only base count");

endmodule : tsc_regs

`default_nettype wire

// File: tsc_defs.svh
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define TSC_ADDR_STBY_THRESH 8'h43
`define TSC_ADDR_BASE1 8'h50
`define TSC_ADDR_BASE2 8'h51
`define TSC_ADDR_BASE3 8'h52
`define TSC_ADDR_HOLD_SEL 8'h60
`define TSC_ADDR_HOLD_CFG 8'h61
`define TSC_ADDR_CAL_GAIN 8'h80
`define TSC_ADDR_CAL1 8'hb1
`define TSC_ADDR_CAL2 8'hb2
`define TSC_ADDR_CAL3 8'hb3
`define TSC_ADDR_CAL_LSB 8'hb9
`define TSC_ADDR_PRODUCT 8'hfd
`define TSC_ADDR_VENDOR 8'hfe
`define TSC_ADDR_REVISION 8'hff

// ****************************************************************
// reset values and writable masks
// ****************************************************************
`define TSC_RST_STBY_THRESH 7'h40
`define TSC_RST_BASE 8'hc8
`define TSC_RST_HOLD_SEL 3'h0
`define TSC_RST_HOLD_CFG 8'h22
`define TSC_RST_CAL_GAIN 6'h00
`define TSC_RST_CAL 10'h000
`define TSC_MASK_HOLD_CFG 8'h77

// ****************************************************************
// field positions in the hold key config register
// ****************************************************************
`define TSC_CFG_STBY_EN 6
`define TSC_CFG_STBY_TIME_HI 5
`define TSC_CFG_STBY_TIME_LO 4
`define TSC_CFG_ACT_EN 2
`define TSC_CFG_ACT_TIME_HI 1
`define TSC_CFG_ACT_TIME_LO 0

// ****************************************************************
// calibration limits and timing
// ****************************************************************
`define TSC_CAL_MIN 10'h000
`define TSC_CAL_MAX 10'h3ff
`define TSC_BASE_SAMPLES_LOG2 8
`define TSC_CORE_CLK_MHZ 100
// shortest hold time; longer codes double it each step
`define TSC_HOLD_TIME_BASE_MS 280
`define TSC_HOLD_BASE_CYCLES (`TSC_HOLD_TIME_BASE_MS * 1000 * `TSC_CORE_CLK_MHZ)

`endif

// File: tsc_pkg.sv
package tsc_pkg;

  typedef enum logic [1:0] {
    HOLD_280MS = 2'b00,
    HOLD_560MS = 2'b01,
    HOLD_1120MS = 2'b10,
    HOLD_2240MS = 2'b11
  } tsc_hold_code_e;

  typedef enum logic [1:0] {
    HOLD_IDLE = 2'b00,
    HOLD_COUNT = 2'b01,
    HOLD_FIRED = 2'b11
  } tsc_hold_state_e;

  typedef logic [7:0] tsc_byte_t;

  function automatic logic [31:0] tsc_hold_cycles(input int base, input logic [1:0] code);
    return 32'(base) << code;
  endfunction : tsc_hold_cycles

endpackage : tsc_pkg

// File: tsc_base_acc.sv
`timescale 1ns/1ps
`default_nettype none

module tsc_base_acc import tsc_pkg::*; #(
  parameter int SAMPLES_LOG2 = 8,
  parameter logic [1:0] CHANNEL = 2'h0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // raw samples
  input wire logic sample_valid,
  input wire logic [1:0] sample_channel,
  input wire logic [15:0] sample_count,
  // finished base word
  output logic base_valid,
  output logic [15:0] base_word
);
  localparam int ACC_W = 16 + SAMPLES_LOG2;

  logic [ACC_W-1:0] acc_q;
  logic [SAMPLES_LOG2-1:0] cnt_q;
  logic [ACC_W-1:0] acc_d;
  logic take;

  assign take = sample_valid && (sample_channel == CHANNEL);
  assign acc_d = acc_q + ACC_W'(sample_count);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_q <= '0;
      cnt_q <= '0;
      base_valid <= 1'b0;
      base_word <= 16'h0000;
    end else begin
      base_valid <= 1'b0;
      if (take) begin
        if (&cnt_q) begin
          base_word <= acc_d[ACC_W-1 -: 16];
          base_valid <= 1'b1;
          acc_q <= '0;
          cnt_q <= '0;
        end else begin
          acc_q <= acc_d;
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  adder_clear_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (take && (&cnt_q)) |=> (acc_q == '0) && base_valid && (base_word == $past(acc_d[ACC_W-1 -: 16])))
    else $error("adder not cleared or base word wrong after last sample");

endmodule : tsc_base_acc

`default_nettype wire

// File: tsc_hold_timer.sv
`timescale 1ns/1ps
`default_nettype none

module tsc_hold_timer import tsc_pkg::*; #(
  parameter int HOLD_BASE_CYCLES = 28000000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // qualified touch of the chosen input
  input wire logic touch,
  input wire logic enable,
  input wire logic [1:0] time_code,
  // one pulse per completed hold
  output logic fire
);
  tsc_hold_state_e state_q;
  logic [31:0] cnt_q;
  logic [31:0] target;

  assign target = tsc_hold_cycles(HOLD_BASE_CYCLES, time_code);

  // one pulse per press: a key kept down after firing must be released first
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= HOLD_IDLE;
      cnt_q <= 32'h0000_0000;
      fire <= 1'b0;
    end else begin
      fire <= 1'b0;
      case (state_q)
        HOLD_IDLE: begin
          cnt_q <= 32'h0000_0000;
          if (enable && touch) begin
            state_q <= HOLD_COUNT;
          end
        end
        HOLD_COUNT: begin
          if (!enable || !touch) begin
            state_q <= HOLD_IDLE;
          end else if (cnt_q >= target - 32'h1) begin
            state_q <= HOLD_FIRED;
            fire <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        HOLD_FIRED: begin
          if (!enable || !touch) begin
            state_q <= HOLD_IDLE;
          end
        end
        default: begin
          state_q <= HOLD_IDLE;
        end
      endcase
    end
  end

  fire_after_hold_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    $rose(fire) |-> $past(touch) && $past(enable) && ($past(cnt_q) >= $past(target) - 32'h1))
    else $error("hold fired before the full hold time");

endmodule : tsc_hold_timer

`default_nettype wire

// File: tsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// host side of the register strobe port
// ****************************************************************
module tsc_host_model (
  // clock
  input wire logic core_clk,
  // register port
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wdata,
  output logic reg_rd_en,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
  end

  // idle address and data are inverted so nothing can lean on a stale value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  // read data is registered, so it is taken just after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : tsc_host_model

`default_nettype wire

// File: tsc_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end

module tsc_regs_bench import tsc_pkg::*;;
  // identity values are arbitrary
  localparam tsc_byte_t PROD = 8'h5a;
  localparam tsc_byte_t VEND = 8'hc3;
  localparam tsc_byte_t REV = 8'h02;
  localparam logic [15:0] RST_TAB [15] = '{16'h4340, 16'h50c8, 16'h51c8, 16'h52c8,
    16'h6000, 16'h6122, 16'h8000, 16'hb100, 16'hb200, 16'hb300, 16'hb900,
    {8'hfd, PROD}, {8'hfe, VEND}, {8'hff, REV}, 16'h4400};
  localparam logic [23:0] WR_TAB [6] = '{24'h43ff7f, 24'h60ff07, 24'h61ff77,
    24'h80ff3f, 24'h5000c8, {16'hfd00, PROD}};
  // negative hold cases: standby, select, config, touch pattern
  localparam logic [19:0] NEG_TAB [3] = '{{4'h0, 8'h01, 8'h40}, {4'h1, 8'h02, 8'h04},
    {4'h0, 8'h01, 8'h04}};
  localparam logic [2:0] NEG_PAT [3] = '{3'h2, 3'h4, 3'h1};

  logic core_clk, sys_rst;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr_en, reg_rd_en, device_standby;
  logic [2:0] standby_channel_enable, active_touch, standby_touch, analog_cal_fail;
  logic [7:0] touch_input_1_delta, touch_input_2_delta, touch_input_3_delta;
  logic [3:0] base_shift;
  logic cal_sample_valid, analog_cal_done;
  logic [1:0] cal_sample_channel, analog_cal_channel;
  logic [15:0] cal_sample_count;
  logic [9:0] analog_cal_value;
  logic [1:0] calib_gain_shift_1, calib_gain_shift_2, calib_gain_shift_3;
  logic hold_key_status_clear, hold_key_event, hold_key_status_flag;
  int failures = 0;
  int n_compared = 0;

  tsc_regs #(
    .HOLD_BASE_CYCLES(20),
    .SAMPLES_LOG2(2),
    .PRODUCT_CODE(PROD),
    .VENDOR_CODE(VEND),
    .REVISION_CODE(REV)
  ) i_tsc_regs (
    .core_clk, .sys_rst, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata,
    .device_standby, .standby_channel_enable, .touch_input_1_delta,
    .touch_input_2_delta, .touch_input_3_delta, .active_touch, .standby_touch,
    .base_shift, .cal_sample_valid, .cal_sample_channel, .cal_sample_count,
    .analog_cal_done, .analog_cal_channel, .analog_cal_value, .analog_cal_fail,
    .calib_gain_shift_1, .calib_gain_shift_2, .calib_gain_shift_3,
    .hold_key_status_clear, .hold_key_event, .hold_key_status_flag
  );

  tsc_host_model i_tsc_host_model (
    .core_clk, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata
  );

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic close_out();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic rchk(input tsc_byte_t a, input tsc_byte_t e);
    tsc_byte_t v;
    i_tsc_host_model.rd(a, v);
    `CHK(v, e)
  endtask : rchk

  task automatic acal(input logic [1:0] ch, input logic [9:0] val);
    @(posedge core_clk);
    analog_cal_done <= 1'b1;
    analog_cal_channel <= ch;
    analog_cal_value <= val;
    @(posedge core_clk);
    analog_cal_done <= 1'b0;
  endtask : acal

  // hold the pattern, count edges until the event, then release and clear
  task automatic press(input logic [2:0] pat, input int tgt, input logic fire);
    int n;
    n = 0;
    @(posedge core_clk);
    active_touch <= pat;
    standby_channel_enable <= pat;
    while (hold_key_event !== 1'b1 && n < tgt + 8) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    `CHK(n >= tgt && n <= tgt + 5, fire)
    `CHK(hold_key_status_flag, fire)
    if (fire && n == tgt + 8)
      close_out();
    @(posedge core_clk);
    #1;
    `CHK(hold_key_event, 1'b0)
    @(posedge core_clk);
    active_touch <= 3'h0;
    standby_channel_enable <= 3'h0;
    hold_key_status_clear <= 1'b1;
    @(posedge core_clk);
    hold_key_status_clear <= 1'b0;
    @(posedge core_clk);
    #1;
    `CHK(hold_key_status_flag, 1'b0)
  endtask : press

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    sys_rst = 1'b1;
    device_standby = 1'b0;
    standby_channel_enable = 3'h0;
    touch_input_1_delta = 8'h00;
    touch_input_2_delta = 8'h00;
    touch_input_3_delta = 8'h00;
    active_touch = 3'h0;
    base_shift = 4'h0;
    cal_sample_valid = 1'b0;
    cal_sample_channel = 2'h0;
    cal_sample_count = 16'h0000;
    analog_cal_done = 1'b0;
    analog_cal_channel = 2'h0;
    analog_cal_value = 10'h000;
    hold_key_status_clear = 1'b0;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (RST_TAB[i])
      rchk(RST_TAB[i][15:8], RST_TAB[i][7:0]);
    foreach (WR_TAB[i]) begin
      i_tsc_host_model.wr(WR_TAB[i][23:16], WR_TAB[i][15:8]);
      rchk(WR_TAB[i][23:16], WR_TAB[i][7:0]);
    end
    // standby compare: enabled, not enabled, and equal to the threshold
    i_tsc_host_model.wr(8'h43, 8'h10);
    @(posedge core_clk);
    device_standby <= 1'b1;
    standby_channel_enable <= 3'h5;
    touch_input_1_delta <= 8'h11;
    touch_input_2_delta <= 8'h11;
    touch_input_3_delta <= 8'h10;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK(standby_touch, 3'h1)
    // base count, a channel-3 sample must not disturb the sum
    @(posedge core_clk);
    base_shift <= 4'h4;
    for (int i = 0; i < 5; i++) begin
      cal_sample_valid <= 1'b1;
      cal_sample_channel <= (i == 0) ? 2'h3 : 2'h1;
      cal_sample_count <= (i == 0) ? 16'hffff : 16'h0ab0;
      @(posedge core_clk);
    end
    cal_sample_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
    rchk(8'h51, 8'hab);
    rchk(8'h50, 8'hc8);
    // analog calibration, both failure codes and an ignored channel
    acal(2'h0, 10'h2b5);
    acal(2'h1, 10'h000);
    acal(2'h2, 10'h3ff);
    acal(2'h3, 10'h155);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(analog_cal_fail, 3'h6)
    rchk(8'hb1, 8'had);
    rchk(8'hb3, 8'hff);
    rchk(8'hb9, 8'h31);
    // gain fields
    i_tsc_host_model.wr(8'h80, 8'h24);
    #1;
    `CHK({calib_gain_shift_3, calib_gain_shift_2, calib_gain_shift_1}, 6'h24)
    // hold key: every time code in both states
    touch_input_3_delta <= 8'h20;
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 4; c++) begin
        device_standby <= m[0];
        i_tsc_host_model.wr(8'h60, m[0] ? 8'h02 : 8'h01);
        i_tsc_host_model.wr(8'h61, m[0] ? 8'(8'h40 | (c << 4)) : 8'(8'h04 | c));
        press(m[0] ? 3'h4 : 3'h2, 20 << c, 1'b1);
      end
    end
    // wrong-state enable or wrong input gives no event
    foreach (NEG_TAB[i]) begin
      device_standby <= NEG_TAB[i][16];
      i_tsc_host_model.wr(8'h60, NEG_TAB[i][15:8]);
      i_tsc_host_model.wr(8'h61, NEG_TAB[i][7:0]);
      press(NEG_PAT[i], 20, 1'b0);
    end
    close_out();
  end
endmodule : tsc_regs_bench

`default_nettype wire
